// ===== inc/sec_pkg.sv
/*
  Package for the segment environment setup checker: descriptor field layout,
  APB register offsets, reset values and mode encodings.
  Assumes a 32-bit APB master and 64-bit descriptor images split in two words.
*/
`default_nettype none
package sec_pkg;
  // Descriptor field positions in the 64-bit image.
  localparam int BASE_LO = 0;
  localparam int LIM_LO  = 32;
  localparam int LIM_W   = 20;
  localparam int TYPE_LO = 52;
  localparam int ACC_BIT = 52;
  localparam int S_BIT   = 56;
  localparam int DPL_LO  = 57;
  localparam int P_BIT   = 59;
  localparam int AV_BIT  = 60;
  localparam int IG_BIT  = 61;
  localparam int DB_BIT  = 62;
  localparam int G_BIT   = 63;
  localparam int NUM_DESC = 6;
  localparam int CODE_IDX  = 0;
  localparam int STACK_IDX = 1;
  // Values expected by the mode checks.
  localparam logic [19:0] LIM_64K      = 20'hffff;
  localparam logic [11:0] GRAN_FILL    = 12'hfff;
  localparam int          GRAN_SHIFT   = 12;
  localparam logic [1:0]  PL_USER      = 2'h3;
  localparam logic [1:0]  PL_KERNEL    = 2'h0;
  localparam logic [3:0]  TYPE_DATA_RW = 4'h3;
  localparam int          SEL_SHIFT    = 4;
  // APB byte offsets. Descriptor n: low word at DESC_BASE + 16n, high at +4,
  // selector at +8.
  localparam logic [11:0] DESC_BASE   = 12'h000;
  localparam logic [11:0] DESC_STRIDE = 12'h010;
  localparam logic [11:0] OFF_HI      = 12'h004;
  localparam logic [11:0] OFF_SEL     = 12'h008;
  localparam logic [11:0] CTRL_OFF    = 12'h100;
  localparam logic [11:0] STAT_OFF    = 12'h104;
  localparam logic [11:0] LIMIT_OFF   = 12'h108;
  localparam logic [63:0] DESC_RESET  = 64'h0;
  localparam logic [31:0] CTRL_RESET  = 32'h0;
  // Control fields.
  localparam int CPL_LO   = 0;
  localparam int VM_BIT   = 2;
  localparam int PE_BIT   = 3;
  localparam int LEG_BIT  = 4;
  localparam int SPL_LO   = 5;
  localparam int LSEL_LO  = 8;
  typedef enum logic [2:0] {
    SEC_REAL  = 3'b001,
    SEC_PROT  = 3'b010,
    SEC_V86   = 3'b100
  } sec_mode_t;
endpackage
`default_nettype wire

// ===== hdl/sec_checker.sv
/*
  Segment environment setup checker: holds the legacy code, stack and four data
  descriptor registers, reports per-register environment consistency and
  scaled limits. Assumes an APB master on REF_CLK and a core that raises
  LEGACY_LOAD with a checked descriptor when a legacy segment load retires.
*/
// Functional notes
// - Native (APB) descriptor writes store values without protection checks; code and stack writes clear bits 61:60.
// - Legacy segment loads are checked at load time; failures raise a fault.
// - No accessed-bit write-back to in-memory tables on native writes.
// - No coherency with memory copies; registers change only on explicit writes.
// - Instruction-set switches leave base, limit and attributes untouched.
// - Instruction-set switches rewrite the current privilege level with the rest of the control word.
// - Virtual-8086 code is data read/write; execute-permission faults ignored.
// - Virtual-8086 limits must be 0xFFFF or spurious limit faults arise.
// - Granular limit scales as limit shifted left twelve with ones below.
`default_nettype none
module sec_checker #(
  parameter int NDESC = sec_pkg::NUM_DESC
) (
  // Clock, reset, enable
  input  wire logic        REF_CLK,
  input  wire logic        RSTN,
  input  wire logic        CLK_EN,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Legacy segment load from the core
  input  wire logic        LEGACY_LOAD,
  input  wire logic [2:0]  LEGACY_IDX,
  input  wire logic [63:0] LEGACY_DESC,
  input  wire logic [15:0] LEGACY_SEL,
  input  wire logic        LEGACY_NULL,
  // Status
  output logic [NDESC-1:0] DESC_ENV_OK,
  output logic             ENV_OK,
  output logic             GENERAL_PROTECTION_FAULT
);

  logic [63:0] desc_q [NDESC];
  logic [15:0] sel_q  [NDESC];
  logic [31:0] ctrl_q;
  logic        fault_q;
  logic [31:0] prdata_q;
  logic [NDESC-1:0] env_vec_q;
  logic        env_all_q;

  wire logic [1:0] current_privilege_level = ctrl_q[sec_pkg::CPL_LO +: 2];
  wire logic       virtual_8086_flag       = ctrl_q[sec_pkg::VM_BIT];
  wire logic       protection_enable_bit   = ctrl_q[sec_pkg::PE_BIT];
  wire logic       legacy_set              = ctrl_q[sec_pkg::LEG_BIT];
  wire logic [1:0] saved_privilege_level   = ctrl_q[sec_pkg::SPL_LO +: 2];
  wire logic [2:0] limit_sel               = ctrl_q[sec_pkg::LSEL_LO +: 3];

  wire sec_pkg::sec_mode_t mode =
    !protection_enable_bit ? sec_pkg::SEC_REAL :
    virtual_8086_flag      ? sec_pkg::SEC_V86  : sec_pkg::SEC_PROT;

  // Granular limit scaling used by the limit view, with either instruction set.
  function automatic logic [31:0] eff_limit(input logic [63:0] d);
    logic [19:0] lim;
    lim = d[sec_pkg::LIM_LO +: sec_pkg::LIM_W];
    if (d[sec_pkg::G_BIT])
      eff_limit = {lim, sec_pkg::GRAN_FILL};
    else
      eff_limit = {12'h000, lim};
  endfunction

  // Data read/write expand-up, ignoring the accessed bit.
  function automatic logic is_data_rw(input logic [63:0] d);
    is_data_rw = (d[sec_pkg::TYPE_LO + 1 +: 3] == sec_pkg::TYPE_DATA_RW[3:1]);
  endfunction

  // Fields required in every 64K legacy mode (real and virtual-8086).
  function automatic logic flat64k_ok(input logic [63:0] d, input logic [15:0] s);
    flat64k_ok = (d[sec_pkg::LIM_LO +: sec_pkg::LIM_W] == sec_pkg::LIM_64K)
               && !d[sec_pkg::G_BIT] && !d[sec_pkg::DB_BIT]
               && (d[31:0] == {12'h000, s, 4'h0})
               && is_data_rw(d)
               && d[sec_pkg::P_BIT] && d[sec_pkg::ACC_BIT];
  endfunction

  // Per-register consistency against the current mode.
  function automatic logic desc_ok(input logic [63:0] d, input logic [15:0] s,
                                   input int idx, input sec_pkg::sec_mode_t m,
                                   input logic [1:0] cpl);
    logic [1:0] dpl;
    logic       code_conf;
    logic       nonsys;
    dpl       = d[sec_pkg::DPL_LO +: 2];
    code_conf = d[sec_pkg::TYPE_LO + 3] && d[sec_pkg::TYPE_LO + 2];
    nonsys    = d[sec_pkg::S_BIT];
    desc_ok   = 1'b0;
    case (m)
      sec_pkg::SEC_REAL:
        desc_ok = nonsys && flat64k_ok(d, s) &&
                  ((idx != sec_pkg::STACK_IDX) || (dpl == sec_pkg::PL_KERNEL));
      sec_pkg::SEC_V86:
        desc_ok = nonsys && flat64k_ok(d, s) &&
                  (dpl == sec_pkg::PL_USER);
      sec_pkg::SEC_PROT:
        if (idx == sec_pkg::CODE_IDX)
          desc_ok = nonsys && d[sec_pkg::ACC_BIT] && d[sec_pkg::P_BIT] &&
                    (code_conf || dpl == cpl);
        else if (idx == sec_pkg::STACK_IDX)
          desc_ok = nonsys && d[sec_pkg::ACC_BIT] && d[sec_pkg::P_BIT] &&
                    (dpl == cpl);
        else
          desc_ok = nonsys && d[sec_pkg::ACC_BIT] &&
                    (s[15:2] == 14'h0000 ? !d[sec_pkg::P_BIT] : d[sec_pkg::P_BIT]) &&
                    (dpl >= cpl);
      default:
        desc_ok = 1'b0;
    endcase
  endfunction

  // Checks applied to a legacy-set segment load before it is committed.
  function automatic logic legacy_load_ok(input logic [63:0] d, input logic nul,
                                          input logic [2:0] idx,
                                          input logic [1:0] cpl);
    logic [1:0] dpl;
    dpl = d[sec_pkg::DPL_LO +: 2];
    legacy_load_ok = 1'b0;
    if (idx >= 3'(NDESC))
      legacy_load_ok = 1'b0;
    else if (nul)
      legacy_load_ok = (idx > 3'(sec_pkg::STACK_IDX));
    else if (!d[sec_pkg::S_BIT] || !d[sec_pkg::P_BIT])
      legacy_load_ok = 1'b0;
    else if (idx == 3'(sec_pkg::STACK_IDX))
      legacy_load_ok = (dpl == cpl) && is_data_rw(d);
    else
      legacy_load_ok = (dpl >= cpl);
  endfunction

  // APB decode.
  wire logic        apb_acc    = PSEL && PENABLE;
  wire logic        apb_wr     = apb_acc && PWRITE;
  wire logic [3:0]  dsc_idx    = PADDR[7:4];
  wire logic [3:0]  dsc_word   = PADDR[3:0];
  wire logic        in_desc    = (PADDR[11:8] == 4'h0) && (dsc_idx < 4'(NDESC)) &&
                                 (dsc_word <= sec_pkg::OFF_SEL[3:0]) &&
                                 (PADDR[1:0] == 2'b00);
  wire logic        is_ctrl    = (PADDR == sec_pkg::CTRL_OFF);
  wire logic        is_stat    = (PADDR == sec_pkg::STAT_OFF);
  wire logic        is_limit   = (PADDR == sec_pkg::LIMIT_OFF);
  wire logic        mapped     = in_desc || is_ctrl || is_stat || is_limit;
  // The status word takes a write of its fault bit, so only the limit view is read-only.
  wire logic        ro_write   = PWRITE && is_limit;
  // Descriptor registers are writable only while the native set runs.
  wire logic        desc_lock  = in_desc && PWRITE && legacy_set;
  wire logic        acc_err    = !mapped || ro_write || desc_lock;

  wire logic [NDESC-1:0] ok_vec;
  genvar gi;
  generate
    for (gi = 0; gi < NDESC; gi++)
    begin : g_chk
      assign ok_vec[gi] = desc_ok(desc_q[gi], sel_q[gi], gi, mode,
                                  current_privilege_level);
    end
  endgenerate

  // Virtual-8086 entry needs privilege 3 either now or in the saved level.
  // It is judged for the whole environment, since an entry by return carries it
  // in the saved level while the current level is still that of the caller.
  wire logic v86_entry_ok = (current_privilege_level == sec_pkg::PL_USER) ||
                            (saved_privilege_level == sec_pkg::PL_USER);
  wire logic env_ok_w = (&ok_vec) && ((mode != sec_pkg::SEC_V86) || v86_entry_ok);

  wire logic load_ok = legacy_load_ok(LEGACY_DESC, LEGACY_NULL, LEGACY_IDX,
                                      current_privilege_level);
  wire logic load_go = LEGACY_LOAD && legacy_set;

  // A selection past the last descriptor shows descriptor 0, not an undefined word.
  wire logic [2:0]  lim_idx = (limit_sel < 3'(NDESC)) ? limit_sel : 3'h0;

  wire logic [63:0] rd_desc = desc_q[dsc_idx[2:0]];
  wire logic [31:0] rd_dword =
    (dsc_word == 4'h0) ? rd_desc[31:0] :
    (dsc_word == sec_pkg::OFF_HI[3:0]) ? rd_desc[63:32] :
    {16'h0000, sel_q[dsc_idx[2:0]]};
  wire logic [31:0] rd_mux =
    in_desc  ? rd_dword :
    is_ctrl  ? ctrl_q :
    is_stat  ? {fault_q, 31'(ok_vec)} :
    is_limit ? eff_limit(desc_q[lim_idx]) : 32'h0;

  // Control writes change the control register only; descriptors are never touched by
  // a switch of instruction set, which keeps base, limit and attributes intact.
  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
      ctrl_q <= sec_pkg::CTRL_RESET;
    else if (CLK_EN && apb_wr && is_ctrl)
      ctrl_q <= PWDATA;
  end

  // Descriptor storage. Native writes are stored with no checks and no table
  // write-back, code and stack with bits 61:60 cleared; memory copies never update these registers.
  generate
    for (gi = 0; gi < NDESC; gi++)
    begin : g_reg
      wire logic hit = apb_wr && in_desc && !legacy_set && (dsc_idx == 4'(gi));
      wire logic wr_lo  = hit && (dsc_word == 4'h0);
      wire logic wr_hi  = hit && (dsc_word == sec_pkg::OFF_HI[3:0]);
      wire logic wr_sel = hit && (dsc_word == sec_pkg::OFF_SEL[3:0]);
      wire logic ld_hit = load_go && load_ok && (LEGACY_IDX == 3'(gi));
      always_ff @(posedge REF_CLK or negedge RSTN)
      begin
        if (!RSTN)
        begin
          desc_q[gi] <= sec_pkg::DESC_RESET;
          sel_q[gi]  <= 16'h0000;
        end
        else if (CLK_EN)
        begin
          if (wr_lo)
            desc_q[gi][31:0] <= PWDATA;
          else if (wr_hi)
            desc_q[gi][63:32] <= (gi < 2) ? (PWDATA & 32'hcfffffff) : PWDATA;
          else if (wr_sel)
            sel_q[gi] <= PWDATA[15:0];
          else if (ld_hit)
          begin
            desc_q[gi] <= LEGACY_DESC & 64'hcfffffffffffffff;
            sel_q[gi]  <= LEGACY_SEL;
          end
        end
      end
    end
  endgenerate

  // Sticky load fault; a new fault wins over a clear in the same cycle.
  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
      fault_q <= 1'b0;
    else if (CLK_EN)
    begin
      if (load_go && !load_ok)
        fault_q <= 1'b1;
      else if (apb_wr && is_stat && PWDATA[31])
        fault_q <= 1'b0;
    end
  end

  // The status outputs are registered so the core never sees a decode glitch;
  // they trail the register that changed them by one clock.
  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      env_vec_q <= {NDESC{1'b0}};
      env_all_q <= 1'b0;
    end
    else if (CLK_EN)
    begin
      env_vec_q <= ok_vec;
      env_all_q <= env_ok_w;
    end
  end

  // Read data is taken in the setup cycle, so it stands through the whole
  // access phase although no wait state is ever inserted.
  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
      prdata_q <= 32'h0;
    else if (CLK_EN && PSEL && !PENABLE && !PWRITE)
      prdata_q <= rd_mux;
  end

  assign PRDATA                   = prdata_q;
  assign PREADY                   = 1'b1;
  assign PSLVERR                  = apb_acc && acc_err;
  assign DESC_ENV_OK              = env_vec_q;
  assign ENV_OK                   = env_all_q;
  assign GENERAL_PROTECTION_FAULT = fault_q;

endmodule
`default_nettype wire

// ===== test/sec_checker_properties.sv
/*
  Port checker of the segment environment setup checker.
  Bound to every checker instance; sees only its ports.
*/
`default_nettype none
module sec_checker_properties #(
  parameter int NDESC = 6
) (
  // Clock and reset
  input wire logic             REF_CLK,
  input wire logic             RSTN,
  input wire logic             CLK_EN,
  // APB
  input wire logic             PSEL,
  input wire logic             PENABLE,
  input wire logic             PWRITE,
  input wire logic [11:0]      PADDR,
  input wire logic [31:0]      PWDATA,
  input wire logic [31:0]      PRDATA,
  input wire logic             PREADY,
  input wire logic             PSLVERR,
  // Core side and status
  input wire logic             LEGACY_LOAD,
  input wire logic [NDESC-1:0] DESC_ENV_OK,
  input wire logic             ENV_OK,
  input wire logic             GENERAL_PROTECTION_FAULT
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  logic chg_q;
  logic chg2_q;
  logic rd_q;
  // All start high so that the first edges after reset are never judged. The
  // indication is registered, so a change shows one edge after its cause.
  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      chg_q  <= 1'b1;
      chg2_q <= 1'b1;
      rd_q   <= 1'b1;
    end
    else
    begin
      chg_q  <= (PSEL && PENABLE && PWRITE) || LEGACY_LOAD || !CLK_EN;
      chg2_q <= chg_q;
      rd_q   <= PSEL && !PENABLE && !PWRITE;
    end
  end
  sequence clr_s;
    PSEL && PENABLE && PWRITE && PADDR == 12'h104 && PWDATA[31];
  endsequence
  sequence quiet_s;
    CLK_EN && !LEGACY_LOAD;
  endsequence
  a_ready_const: assert property (PREADY) else $error("Ready low");
  a_fault_cause: assert property ($rose(GENERAL_PROTECTION_FAULT) |-> $past(LEGACY_LOAD))
    else $error("Fault without legacy load");
  a_fault_hold: assert property (GENERAL_PROTECTION_FAULT && !PWDATA[31] |=> GENERAL_PROTECTION_FAULT)
    else $error("Fault dropped");
  a_fault_clear: assert property (clr_s ##0 quiet_s |=> !GENERAL_PROTECTION_FAULT)
    else $error("Fault not cleared");
  a_limit_ro: assert property (PSEL && PENABLE && PWRITE && PADDR == 12'h108 |-> PSLVERR)
    else $error("Read-only write accepted");
  a_unmapped_err: assert property (PSEL && PENABLE && PADDR > 12'h108 |-> PSLVERR)
    else $error("Unmapped access accepted");
  a_env_all: assert property (ENV_OK |-> &DESC_ENV_OK) else $error("Summary without all");
  a_ok_stable: assert property (!chg_q && !chg2_q |-> $stable(DESC_ENV_OK))
    else $error("Indication changed untouched");
  a_rdata_hold: assert property (!rd_q |-> $stable(PRDATA)) else $error("Read data moved");
endmodule
bind sec_checker sec_checker_properties #(.NDESC(NDESC)) sec_checker_properties_i (
  .REF_CLK(REF_CLK), .RSTN(RSTN), .CLK_EN(CLK_EN), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .LEGACY_LOAD(LEGACY_LOAD), .DESC_ENV_OK(DESC_ENV_OK), .ENV_OK(ENV_OK),
  .GENERAL_PROTECTION_FAULT(GENERAL_PROTECTION_FAULT));
`default_nettype wire

// ===== test/sec_checker_bench.sv
/*
  Self-checking bench of the segment environment setup checker.
  Drives APB and legacy loads itself; the port checker is bound separately.
*/
`default_nettype none
module sec_checker_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic             clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, ld = 0, serr;
  logic             cen = 1, lnul = 0;
  logic [11:0]      pa = 0;
  logic [31:0]      pwd = 0, rd;
  logic [2:0]       lidx = 0;
  logic [63:0]      ldesc = 0;
  logic [15:0]      lsel = 0, sel [6];
  logic [19:0]      lim;
  wire logic [31:0] prdata;
  wire logic        pready, pslverr, env_ok, fault;
  wire logic [5:0]  ok;
  int               err_count = 0, comparisons = 0, seed = 32'h5d09;
  logic [31:0]      mctl [5] = '{32'h0, 32'ha, 32'hf, 32'hf, 32'h6c};
  logic [1:0]       mdpl [5] = '{2'h0, 2'h2, 2'h0, 2'h3, 2'h3};
  logic [5:0]       mexp [5] = '{6'h3f, 6'h11, 6'h00, 6'h17, 6'h3f};
  always #2 clk = ~clk;
  sec_checker sec_checker_i (.REF_CLK(clk), .RSTN(rstn), .CLK_EN(cen), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .LEGACY_LOAD(ld), .LEGACY_IDX(lidx), .LEGACY_DESC(ldesc),
    .LEGACY_SEL(lsel), .LEGACY_NULL(lnul), .DESC_ENV_OK(ok), .ENV_OK(env_ok),
    .GENERAL_PROTECTION_FAULT(fault));
  task check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task end_of_test;
    $display("Mismatches %0d, comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Ends one idle edge after release, so no signal is assigned twice in a step.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task wdesc(input int i, input logic [63:0] v, input logic [15:0] s);
    apb(1'b1, 12'(16 * i), v[31:0]);
    apb(1'b1, 12'(16 * i + 4), v[63:32]);
    apb(1'b1, 12'(16 * i + 8), {16'h0, s});
  endtask
  task rdesc(input int i, input logic [63:0] e);
    logic [31:0] lo;
    apb(1'b0, 12'(16 * i), 32'h0);
    lo = rd;
    apb(1'b0, 12'(16 * i + 4), 32'h0);
    check({rd, lo}, e);
  endtask
  task lload(input logic [2:0] i, input logic [63:0] v, input logic [15:0] s, input logic n);
    ld <= 1'b1;
    lidx <= i;
    ldesc <= v;
    lsel <= s;
    lnul <= n;
    @(posedge clk);
    ld <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  // Flat 64K data read/write, accessed, 16-bit descriptor.
  function logic [63:0] mk(input logic [31:0] b, input logic [1:0] dpl, input logic p);
    mk = {4'h0, p, dpl, 1'b1, sec_pkg::TYPE_DATA_RW, sec_pkg::LIM_64K, b};
  endfunction
  initial
  begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    apb(1'b0, sec_pkg::CTRL_OFF, 32'h0);
    check(rd, sec_pkg::CTRL_RESET);
    rdesc(2, sec_pkg::DESC_RESET);
    check(fault, 1'b0);
    for (int k = 0; k < 5; k++)
    begin
      apb(1'b1, sec_pkg::CTRL_OFF, mctl[k]);
      for (int i = 0; i < 6; i++)
      begin
        sel[i] = 16'($random(seed));
        wdesc(i, mk({12'h0, sel[i], 4'h0}, mdpl[k], 1'b1), sel[i]);
      end
      if (k == 1)
      begin
        wdesc(1, mk(32'h0, 2'h3, 1'b1), 16'h8);
        wdesc(2, mk(32'h0, 2'h2, 1'b1) & ~(64'h1 << 56), 16'h8);
        wdesc(3, mk(32'h0, 2'h1, 1'b1), 16'h8);
        wdesc(4, mk(32'h0, 2'h2, 1'b0), 16'h0);
        wdesc(5, mk(32'h0, 2'h2, 1'b0), 16'h8);
      end
      if (k == 3)
      begin
        wdesc(3, mk({12'h0, sel[3], 4'h0} + 32'h10, 2'h3, 1'b1), sel[3]);
        wdesc(5, mk({12'h0, sel[5], 4'h0}, 2'h3, 1'b1) ^ (64'h1 << 32), sel[5]);
      end
      apb(1'b0, sec_pkg::STAT_OFF, 32'h0);
      check(rd[5:0], mexp[k]);
      check(ok, mexp[k]);
      check(env_ok, mexp[k] == 6'h3f);
      check(fault, 1'b0);
    end
    apb(1'b1, sec_pkg::CTRL_OFF, 32'hc);
    apb(1'b0, sec_pkg::STAT_OFF, 32'h0);
    check(rd[5:0], 6'h3f);
    check(ok, 6'h3f);
    check(env_ok, 1'b0);
    apb(1'b1, sec_pkg::CTRL_OFF, 32'h1f);
    apb(1'b1, sec_pkg::CTRL_OFF, 32'hf);
    apb(1'b0, sec_pkg::CTRL_OFF, 32'h0);
    check(rd, 32'hf);
    cen <= 1'b0;
    apb(1'b1, sec_pkg::CTRL_OFF, 32'h0);
    cen <= 1'b1;
    apb(1'b0, sec_pkg::CTRL_OFF, 32'h0);
    check(rd, 32'hf);
    rdesc(2, mk({12'h0, sel[2], 4'h0}, 2'h3, 1'b1));
    apb(1'b1, sec_pkg::CTRL_OFF, 32'h18);
    lload(3'h1, mk(32'h1234, 2'h0, 1'b1) | (64'h3 << 60), 16'h10, 1'b0);
    check(fault, 1'b0);
    rdesc(1, mk(32'h1234, 2'h0, 1'b1));
    lload(3'h2, mk(32'h0, 2'h0, 1'b0), 16'h8, 1'b0);
    check(fault, 1'b1);
    rdesc(2, mk({12'h0, sel[2], 4'h0}, 2'h3, 1'b1));
    apb(1'b1, 12'h020, 32'h0);
    check(serr, 1'b1);
    apb(1'b1, sec_pkg::STAT_OFF, 32'h8000_0000);
    check(serr, 1'b0);
    check(fault, 1'b0);
    lload(3'h5, 64'h0, 16'h0, 1'b1);
    check(fault, 1'b0);
    lload(3'h1, 64'h0, 16'h0, 1'b1);
    check(fault, 1'b1);
    apb(1'b1, sec_pkg::CTRL_OFF, 32'h400);
    lim = 20'($random(seed));
    apb(1'b1, 12'h044, {12'h800, lim});
    apb(1'b0, sec_pkg::LIMIT_OFF, 32'h0);
    check(rd, {lim, sec_pkg::GRAN_FILL});
    apb(1'b1, sec_pkg::LIMIT_OFF, 32'h0);
    check(serr, 1'b1);
    apb(1'b0, 12'h200, 32'h0);
    check(serr, 1'b1);
    end_of_test;
  end
  initial
  begin
    #100000;
    err_count++;
    end_of_test;
  end
endmodule
`default_nettype wire
